// ### rtl/odo_input.sv
// Wheel pulse counter with configurable direction polarity
// Overview of operation
// - Count rising edges of the wheel pulse; falling edges ignored.
// - After reset, high direction level means forward, low means reverse.
// - Polarity command with value 1 inverts direction so low means forward; value 0 restores it.
// - Direction taken from io pin 9, pulse from io pin 8.
`timescale 1ns/1ps
module odo_input #(
	parameter int ACC_W = odo_pkg::ACC_WIDTH
) (
	input  wire logic                    sys_clk,
	input  wire logic                    nrst,
	input  wire logic                    multipurpose_io_8,
	input  wire logic                    multipurpose_io_9,
	input  wire logic                    forward_polarity_command,
	input  wire logic                    polarity_value,
	input  wire logic                    acc_clear,
	output logic signed [ACC_W-1:0]      pulse_count,
	output logic                         pulse_seen,
	output logic                         forward,
	output logic                         polarity_inverted
);
	// ==========================================================
	// Pin mapping and synchronisers
	logic wheel_pulse_in;
	logic travel_direction_in;
	logic pulse_s;
	logic dir_s;

	assign wheel_pulse_in      = multipurpose_io_8;
	assign travel_direction_in = multipurpose_io_9;

	odo_sync u_sync_pulse (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (wheel_pulse_in),
		.sync_out (pulse_s)
	);

	odo_sync u_sync_dir (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (travel_direction_in),
		.sync_out (dir_s)
	);

	// ==========================================================
	// Edge detect, polarity and accumulator
	logic                    prev_ff;
	logic                    pol_ff;
	logic                    fwd_ff;
	logic                    seen_ff;
	logic signed [ACC_W-1:0] acc_ff;
	logic                    nxt_prev;
	logic                    nxt_pol;
	logic                    nxt_fwd;
	logic                    nxt_seen;
	logic signed [ACC_W-1:0] nxt_acc;
	logic                    rise;
	logic                    dir_fwd;

	always_comb begin
		nxt_prev = pulse_s;
		rise     = pulse_s & ~prev_ff;
		nxt_pol  = forward_polarity_command ? polarity_value : pol_ff;
		dir_fwd  = dir_s ^ pol_ff;
		nxt_fwd  = dir_fwd;
		nxt_seen = rise;
		nxt_acc  = acc_ff;
		if (acc_clear) begin
			nxt_acc = '0;
		end
		if (rise) begin
			if (dir_fwd) begin
				nxt_acc = nxt_acc + ACC_W'(1);
			end else begin
				nxt_acc = nxt_acc - ACC_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prev_ff <= 1'h0;
			pol_ff  <= odo_pkg::POL_RESET;
			fwd_ff  <= 1'h0;
			seen_ff <= 1'h0;
			acc_ff  <= '0;
		end else begin
			prev_ff <= nxt_prev;
			pol_ff  <= nxt_pol;
			fwd_ff  <= nxt_fwd;
			seen_ff <= nxt_seen;
			acc_ff  <= nxt_acc;
		end
	end

	assign pulse_count       = acc_ff;
	assign pulse_seen        = seen_ff;
	assign forward           = fwd_ff;
	assign polarity_inverted = pol_ff;

	// ==========================================================
	// Checks
	a_rise_counts_once: assert property (@(posedge sys_clk) disable iff (!nrst)
		(rise && !acc_clear) |=> (seen_ff && acc_ff != $past(acc_ff)))
		else $error("rising edge not counted");
	a_fall_ignored: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!pulse_s && prev_ff && !acc_clear) |=> (acc_ff == $past(acc_ff)))
		else $error("falling edge changed count");
	a_sync_delay: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(multipurpose_io_8) ##1 multipurpose_io_8 |-> ##1 pulse_s)
		else $error("pulse synchroniser latency wrong");
	a_fwd_up: assert property (@(posedge sys_clk) disable iff (!nrst)
		(rise && dir_fwd && !acc_clear) |=> (acc_ff == $past(acc_ff) + 1))
		else $error("forward edge did not increment");
	a_rev_down: assert property (@(posedge sys_clk) disable iff (!nrst)
		(rise && !dir_fwd && !acc_clear) |=> (acc_ff == $past(acc_ff) - 1))
		else $error("reverse edge did not decrement");
	a_default_polarity: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!pol_ff && dir_s) |=> forward)
		else $error("high level not forward by default");
	a_polarity_cmd: assert property (@(posedge sys_clk) disable iff (!nrst)
		forward_polarity_command |=> (polarity_inverted == $past(polarity_value)))
		else $error("polarity command not applied");
	a_inverted_dir: assert property (@(posedge sys_clk) disable iff (!nrst)
		(pol_ff && !dir_s) |=> forward)
		else $error("inverted low level not forward");
	c_fwd_count: cover property (@(posedge sys_clk) disable iff (!nrst) rise && dir_fwd);
	c_rev_count: cover property (@(posedge sys_clk) disable iff (!nrst) rise && !dir_fwd);
	c_inverted: cover property (@(posedge sys_clk) disable iff (!nrst) pol_ff && rise);
endmodule

// ### rtl/odo_pkg.sv
// Shared constants for the wheel odometer input block
package odo_pkg;
	// ==========================================================
	// Widths and reset values
	localparam int          ACC_WIDTH     = 32;
	localparam logic        POL_RESET     = 1'h0;
	localparam logic [1:0]  SYNC_RESET    = 2'h0;
	// ==========================================================
	// Clock rate, sensor timing limits and distance limits
	localparam int          CLK_HZ        = 25000000;
	localparam int          MIN_PHASE_US  = 100;
	localparam int          MIN_PHASE_CYC = (CLK_HZ / 1000000) * MIN_PHASE_US;
	localparam int          MAX_RATE_HZ   = 10000;
	localparam int          MIN_PERIOD_CYC = (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
	localparam int          MIN_DIST_CM   = 1;
	localparam int          MAX_DIST_CM   = 27;
endpackage

// ### rtl/odo_sync.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module odo_sync (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic async_in,
	output logic      sync_out
);
	logic [1:0] stage_ff;
	logic [1:0] nxt_stage;

	always_comb begin
		nxt_stage = {stage_ff[0], async_in};
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stage_ff <= odo_pkg::SYNC_RESET;
		end else begin
			stage_ff <= nxt_stage;
		end
	end

	assign sync_out = stage_ff[1];
endmodule

// ### tb/odo_sensor.sv
// Vehicle odometer sensor model
`timescale 1ns/1ps
module odo_sensor (
	input  wire logic sys_clk,
	output logic      pulse_pin,
	output logic      dir_pin
);
	initial begin
		pulse_pin = 1'h0;
		dir_pin   = 1'h1;
	end
	// Square wave, each phase held at least the minimum
	task automatic run(input int n, input logic dir, input int ph);
		dir_pin = dir;
		repeat (n) begin
			repeat (ph) @(negedge sys_clk);
			pulse_pin = 1'h1;
			repeat (ph) @(negedge sys_clk);
			pulse_pin = 1'h0;
		end
		// Line then stays constant
	endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the odometer input block
`timescale 1ns/1ps
module tb_top;
	localparam int PH = odo_pkg::MIN_PHASE_CYC;
	logic                                  sys_clk;
	logic                                  nrst;
	logic                                  pin8;
	logic                                  pin9;
	logic                                  cmd = 1'h0;
	logic                                  pval = 1'h0;
	logic                                  clr = 1'h0;
	logic signed [odo_pkg::ACC_WIDTH-1:0]  cnt;
	logic                                  seen;
	logic                                  fwd;
	logic                                  inv;
	int                                    fails = 0;
	int                                    checks_done = 0;
	int                                    seen_n = 0;
	odo_sensor i_odo_sensor (.sys_clk(sys_clk), .pulse_pin(pin8), .dir_pin(pin9));
	odo_input i_odo_input (.sys_clk(sys_clk), .nrst(nrst), .multipurpose_io_8(pin8),
		.multipurpose_io_9(pin9), .forward_polarity_command(cmd), .polarity_value(pval),
		.acc_clear(clr), .pulse_count(cnt), .pulse_seen(seen), .forward(fwd),
		.polarity_inverted(inv));
	// ====
	// Checking
	always @(posedge sys_clk) if (seen === 1'h1) seen_n <= seen_n + 1;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic results();
		$display("fails %0d checks_done %0d", fails, checks_done);
		if (fails == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ====
	// Scenarios
	task automatic t_fwd();
		i_odo_sensor.run(3, 1'h1, PH);
		repeat (4) @(negedge sys_clk);
		chk("count", 32'h3, cnt);
		chk("seen", 32'h3, seen_n);
		chk("fwd", 32'h1, fwd);
	endtask
	task automatic t_rev();
		i_odo_sensor.run(2, 1'h0, PH + 7);
		repeat (4) @(negedge sys_clk);
		chk("count", 32'h1, cnt);
		chk("fwd", 32'h0, fwd);
	endtask
	task automatic t_pol();
		cmd = 1'h1;
		pval = 1'h1;
		@(negedge sys_clk);
		cmd = 1'h0;
		repeat (2) @(negedge sys_clk);
		chk("inv", 32'h1, inv);
		i_odo_sensor.run(1, 1'h0, PH);
		repeat (4) @(negedge sys_clk);
		chk("count", 32'h2, cnt);
		chk("fwd", 32'h1, fwd);
	endtask
	task automatic t_clr();
		clr = 1'h1;
		@(negedge sys_clk);
		clr = 1'h0;
		@(negedge sys_clk);
		chk("count", 32'h0, cnt);
		nrst = 1'h0;
		@(negedge sys_clk);
		chk("inv", 32'h0, inv);
		nrst = 1'h1;
	endtask
	// ====
	// Clock, watchdog and main sequence
	initial begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (100000) @(posedge sys_clk);
		fails++;
		results();
	end
	initial begin
		nrst = 1'h0;
		repeat (6) @(negedge sys_clk);
		nrst = 1'h1;
		t_fwd();
		t_rev();
		t_pol();
		t_clr();
		results();
	end
endmodule
